/* File: design/expander_controller.sv */
// Bus controller end: APB-programmed register-pair writes and reads.
//
// The APB register port was left to the implementer.
module expander_controller
   import expander_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input  wire logic            CLOCK_IN,
   input  wire logic            RST_N_IN,
   input  wire logic            PSEL_IN,
   input  wire logic            PENABLE_IN,
   input  wire logic            PWRITE_IN,
   input  wire logic [7:0]      PADDR_IN,
   input  wire logic [31:0]     PWDATA_IN,
   output logic                 PREADY_OUT,
   output logic                 PSLVERR_OUT,
   output logic [31:0]          PRDATA_OUT,
   expander_link_if.controller  link
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [2:0] {C_IDLE, C_START, C_BITS, C_RSTART, C_STOP} cphase_t;

   typedef struct packed {
      logic [1:0]  sda_sync;
      cphase_t     phase;
      logic [2:0]  div;
      logic [1:0]  quarter;
      logic [3:0]  bit_cnt;
      logic [7:0]  shift;
      logic [1:0]  stage;
      logic [7:0]  remain;
      logic        is_read;
      logic        busy;
      logic        nack;
      logic [7:0]  cmd;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic [7:0]  cnt;
      logic        scl;
      logic        sda;
      logic        ready;
      logic        slverr;
      logic [31:0] prdata;
   } cstate_t;

   cstate_t cur_ff;
   cstate_t nxt_st;
   logic    sda_s;
   logic    tick;
   logic    last_data;

   assign sda_s     = cur_ff.sda_sync[1];
   assign tick      = cur_ff.div == 3'(SCL_HALF_CYCLES - 1);
   assign last_data = cur_ff.remain == 8'h01;

   always_comb begin
      nxt_st = cur_ff;
      nxt_st.sda_sync = {cur_ff.sda_sync[0], link.sda};
      nxt_st.ready  = 1'b0;
      nxt_st.slverr = 1'b0;
      if (PSEL_IN && PENABLE_IN && !cur_ff.ready) begin
         nxt_st.ready = 1'b1;
         if (PWRITE_IN) begin
            if (PADDR_IN == APB_CTRL) begin
               if (PWDATA_IN[CTRL_GO_BIT] && !cur_ff.busy) begin
                  nxt_st.busy    = 1'b1;
                  nxt_st.nack    = 1'b0;
                  nxt_st.is_read = PWDATA_IN[CTRL_READ_BIT];
                  nxt_st.cnt     = PWDATA_IN[CTRL_CNT_LSB +: 8];
                  nxt_st.phase   = C_START;
                  nxt_st.stage   = 2'h0;
                  nxt_st.div     = 3'h0;
                  nxt_st.quarter = 2'h0;
               end
            end else if (PADDR_IN == APB_CMD) begin
               nxt_st.cmd = PWDATA_IN[7:0];
            end else if (PADDR_IN == APB_WDATA) begin
               nxt_st.wdata = PWDATA_IN[7:0];
            end else begin
               nxt_st.slverr = 1'b1;
            end
         end else begin
            unique case (PADDR_IN)
               APB_CTRL:   nxt_st.prdata = {16'h0000, cur_ff.cnt, 8'h00};
               APB_CMD:    nxt_st.prdata = {24'h000000, cur_ff.cmd};
               APB_WDATA:  nxt_st.prdata = {24'h000000, cur_ff.wdata};
               APB_STATUS: nxt_st.prdata = {30'h0, cur_ff.nack, cur_ff.busy};
               APB_RDATA:  nxt_st.prdata = {24'h000000, cur_ff.rdata};
               default: begin
                  nxt_st.prdata = 32'h00000000;
                  nxt_st.slverr = 1'b1;
               end
            endcase
         end
      end
      if (cur_ff.phase != C_IDLE) begin
         nxt_st.div = tick ? 3'h0 : cur_ff.div + 3'h1;
      end
      // Each bit takes four quarters: low-set data, rise, high, fall.
      if (cur_ff.phase != C_IDLE && tick && !(PSEL_IN && PENABLE_IN && PWRITE_IN && !cur_ff.ready &&
                                             PADDR_IN == APB_CTRL && !cur_ff.busy)) begin
         nxt_st.quarter = cur_ff.quarter + 2'h1;
         unique case (cur_ff.phase)
            C_START, C_RSTART: begin
               unique case (cur_ff.quarter)
                  2'h0: begin nxt_st.sda = 1'b1; end
                  2'h1: begin nxt_st.scl = 1'b1; end
                  2'h2: begin nxt_st.sda = 1'b0; end
                  default: begin
                     nxt_st.scl     = 1'b0;
                     nxt_st.phase   = C_BITS;
                     nxt_st.bit_cnt = 4'h0;
                     nxt_st.shift   = {DEV_ADDR, cur_ff.phase == C_RSTART};
                     nxt_st.stage   = cur_ff.phase == C_RSTART ? 2'h3 : 2'h0;
                     nxt_st.remain  = cur_ff.cnt;
                  end
               endcase
            end
            C_BITS: begin
               unique case (cur_ff.quarter)
                  2'h0: begin
                     if (cur_ff.bit_cnt == 4'h8) begin
                        // Acknowledge slot: release after bytes sent, answer on read data.
                        // NACK on last read byte
                        nxt_st.sda = !(cur_ff.stage == 2'h2 && cur_ff.is_read) ? 1'b1 : last_data;
                     end else begin
                        nxt_st.sda = cur_ff.stage == 2'h2 && cur_ff.is_read ? 1'b1 : cur_ff.shift[7];
                     end
                  end
                  2'h1: begin nxt_st.scl = 1'b1; end
                  2'h2: begin
                     if (cur_ff.bit_cnt == 4'h8) begin
                        if (!(cur_ff.stage == 2'h2 && cur_ff.is_read) && sda_s) begin
                           nxt_st.nack = 1'b1;
                        end
                     end else begin
                        nxt_st.shift = {cur_ff.shift[6:0], sda_s};
                     end
                  end
                  default: begin
                     nxt_st.scl = 1'b0;
                     if (cur_ff.bit_cnt != 4'h8) begin
                        nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
                     end else begin
                        nxt_st.bit_cnt = 4'h0;
                        if (cur_ff.nack) begin
                           nxt_st.phase = C_STOP;
                        end else if (cur_ff.stage == 2'h0 || cur_ff.stage == 2'h3) begin
                           nxt_st.stage = cur_ff.stage == 2'h3 ? 2'h2 : 2'h1;
                           nxt_st.shift = cur_ff.stage == 2'h3 ? 8'hFF : cur_ff.cmd;
                           nxt_st.phase = cur_ff.stage == 2'h3 && cur_ff.remain == 8'h00 ? C_STOP : C_BITS;
                        end else if (cur_ff.stage == 2'h1) begin
                           nxt_st.stage = 2'h2;
                           nxt_st.shift = cur_ff.wdata;
                           nxt_st.phase = cur_ff.is_read ? C_RSTART :
                                          cur_ff.remain == 8'h00 ? C_STOP : C_BITS;
                        end else begin
                           // repeat data bytes while count remains
                           if (cur_ff.is_read) begin
                              nxt_st.rdata = cur_ff.shift;
                           end
                           nxt_st.remain = cur_ff.remain - 8'h01;
                           nxt_st.shift  = cur_ff.is_read ? 8'hFF : cur_ff.wdata;
                           nxt_st.phase  = last_data ? C_STOP : C_BITS;
                        end
                     end
                  end
               endcase
            end
            default: begin
               unique case (cur_ff.quarter)
                  2'h0: begin nxt_st.sda = 1'b0; end
                  2'h1: begin nxt_st.scl = 1'b1; end
                  2'h2: begin nxt_st.sda = 1'b1; end
                  default: begin
                     nxt_st.phase = C_IDLE;
                     nxt_st.busy  = 1'b0;
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cur_ff          <= '0;
         cur_ff.sda_sync <= 2'h3;
         cur_ff.phase    <= C_IDLE;
         cur_ff.scl      <= 1'b1;
         cur_ff.sda      <= 1'b1;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign PREADY_OUT        = cur_ff.ready;
   assign PSLVERR_OUT       = cur_ff.slverr;
   assign PRDATA_OUT        = cur_ff.prdata;
   assign link.scl_out      = 1'b0;
   assign link.scl_oe_n     = cur_ff.scl;
   assign link.sda_ctl_out  = 1'b0;
   assign link.sda_ctl_oe_n = cur_ff.sda;

endmodule

/* File: pkg/expander_pkg.sv */
// Shared constants for the serial register-pair expander link.
package expander_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_OUTPUT_LOW      = 8'h02;
   localparam logic [7:0] ADDR_OUTPUT_HIGH     = 8'h03;
   localparam logic [7:0] ADDR_DRIVE_FIRST     = 8'h40;
   localparam logic [7:0] ADDR_DRIVE_LAST      = 8'h43;
   localparam logic [7:0] ADDR_RES_CONNECT_LOW = 8'h46;
   localparam logic [7:0] ADDR_RES_CONNECT_HI  = 8'h47;
   localparam logic [7:0] ADDR_RES_DIR_LOW     = 8'h48;
   localparam logic [7:0] ADDR_RES_DIR_HIGH    = 8'h49;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_OUTPUT      = 8'hFF;
   localparam logic [7:0] RST_DRIVE       = 8'hFF;
   localparam logic [7:0] RST_RES_CONNECT = 8'h00;
   localparam logic [7:0] RST_RES_DIR     = 8'hFF;

   // Drive code that enables only half of the output fingers.
   localparam logic [1:0] DRIVE_HALF = 2'h2;

   // ----------------------------------------
   // Device address and APB map of the controller
   // ----------------------------------------
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h74;
   localparam logic [7:0] APB_CTRL   = 8'h00;
   localparam logic [7:0] APB_CMD    = 8'h04;
   localparam logic [7:0] APB_WDATA  = 8'h08;
   localparam logic [7:0] APB_STATUS = 8'h0C;
   localparam logic [7:0] APB_RDATA  = 8'h10;
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int CTRL_CNT_LSB  = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;

   // System clocks per quarter of a link bit; four quarters make one bit, 1.6 us at 10 MHz.
   localparam int SCL_HALF_CYCLES = 4;

endpackage

/* File: pkg/expander_link_if.sv */
// Two-wire link between controller and expander with open-drain resolution.
interface expander_link_if;
   logic scl_out;
   logic scl_oe_n;
   logic sda_ctl_out;
   logic sda_ctl_oe_n;
   logic sda_dev_out;
   logic sda_dev_oe_n;
   logic scl;
   logic sda;

   // Open-drain wires: any enabled driver pulling low wins, else pulled up.
   assign scl = ~scl_oe_n ? scl_out : 1'b1;
   assign sda = (~sda_ctl_oe_n & ~sda_ctl_out) | (~sda_dev_oe_n & ~sda_dev_out) ? 1'b0 : 1'b1;

   modport device (
      input  scl,
      input  sda,
      output sda_dev_out,
      output sda_dev_oe_n
   );

   modport controller (
      input  scl,
      input  sda,
      output scl_out,
      output scl_oe_n,
      output sda_ctl_out,
      output sda_ctl_oe_n
   );
endinterface

/* File: design/expander_device.sv */
// Expander target: address match, command pointer and register pairs.
module expander_device
   import expander_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input  wire logic        LINK_CLK_IN,
   input  wire logic        RST_N_IN,
   expander_link_if.device  link,
   output logic [15:0]      OUTPUT_LEVEL_OUT,
   output logic [15:0]      RES_CONNECT_OUT,
   output logic [15:0]      RES_PULL_UP_OUT,
   output logic [31:0]      DRIVE_CODE_OUT,
   output logic [15:0]      HALF_DRIVE_OUT
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP} phase_t;

   typedef struct packed {
      logic [1:0]      scl_sync;
      logic [1:0]      sda_sync;
      logic            scl_prev;
      logic            sda_prev;
      phase_t          phase;
      logic [3:0]      bit_cnt;
      logic [7:0]      shift;
      logic            reading;
      logic            acking;
      logic            ack_drive;
      logic            tx_drive;
      logic            ctl_nack;
      logic            sda_out;
      logic            sda_oe_n;
      logic [7:0]      pointer;
      logic [1:0][7:0] out_lvl;
      logic [3:0][7:0] drive;
      logic [1:0][7:0] res_con;
      logic [1:0][7:0] res_dir;
      logic [15:0]     half;
   } state_t;

   state_t cur_ff;
   state_t nxt_st;

   function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a[7:1] == ADDR_OUTPUT_LOW[7:1]) begin
         v = s.out_lvl[a[0]];
      end else if (a >= ADDR_DRIVE_FIRST && a <= ADDR_DRIVE_LAST) begin
         v = s.drive[a[1:0]];
      end else if (a[7:1] == ADDR_RES_CONNECT_LOW[7:1]) begin
         v = s.res_con[a[0]];
      end else if (a[7:1] == ADDR_RES_DIR_LOW[7:1]) begin
         v = s.res_dir[a[0]];
      end
      return v;
   endfunction

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   assign scl_s    = cur_ff.scl_sync[1];
   assign sda_s    = cur_ff.sda_sync[1];
   assign scl_rise = scl_s & ~cur_ff.scl_prev;
   assign scl_fall = ~scl_s & cur_ff.scl_prev;
   assign start_c  = scl_s & cur_ff.scl_prev & cur_ff.sda_prev & ~sda_s;
   assign stop_c   = scl_s & cur_ff.scl_prev & ~cur_ff.sda_prev & sda_s;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      nxt_st = cur_ff;
      nxt_st.scl_sync = {cur_ff.scl_sync[0], link.scl};
      nxt_st.sda_sync = {cur_ff.sda_sync[0], link.sda};
      nxt_st.scl_prev = scl_s;
      nxt_st.sda_prev = sda_s;
      if (start_c) begin
         // A repeated start keeps the pointer, so a new read begins at the register the command byte set.
         // pointer kept across restart
         nxt_st.phase     = ST_ADDR;
         nxt_st.bit_cnt   = 4'h0;
         nxt_st.acking    = 1'b0;
         nxt_st.ack_drive = 1'b0;
         nxt_st.tx_drive  = 1'b0;
      end else if (stop_c) begin
         nxt_st.phase     = ST_IDLE;
         nxt_st.ack_drive = 1'b0;
         nxt_st.tx_drive  = 1'b0;
      end else if (cur_ff.phase != ST_IDLE && cur_ff.phase != ST_SKIP) begin
         if (scl_rise) begin
            if (!cur_ff.acking) begin
               // A byte being sent shifts on the falling edge, so SDA never moves while SCL is high.
               if (cur_ff.phase != ST_RDATA) begin
                  nxt_st.shift = {cur_ff.shift[6:0], sda_s};
               end
               nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
            end else if (cur_ff.phase == ST_RDATA) begin
               nxt_st.ctl_nack = sda_s;
            end
         end else if (scl_fall) begin
            if (cur_ff.acking) begin
               nxt_st.acking    = 1'b0;
               nxt_st.ack_drive = 1'b0;
               nxt_st.bit_cnt   = 4'h0;
               unique case (cur_ff.phase)
                  ST_ADDR: begin
                     // write address leads to command byte
                     nxt_st.phase = cur_ff.reading ? ST_RDATA : ST_CMD;
                  end
                  ST_CMD: begin
                     nxt_st.pointer = cur_ff.shift;
                     nxt_st.phase   = ST_WDATA;
                  end
                  ST_WDATA: begin
                     // capture at fall of acknowledge clock
                     if (cur_ff.pointer[7:1] == ADDR_OUTPUT_LOW[7:1]) begin
                        nxt_st.out_lvl[cur_ff.pointer[0]] = cur_ff.shift;
                     end else if (cur_ff.pointer >= ADDR_DRIVE_FIRST && cur_ff.pointer <= ADDR_DRIVE_LAST) begin
                        nxt_st.drive[cur_ff.pointer[1:0]] = cur_ff.shift;
                     end else if (cur_ff.pointer[7:1] == ADDR_RES_CONNECT_LOW[7:1]) begin
                        nxt_st.res_con[cur_ff.pointer[0]] = cur_ff.shift;
                     end else if (cur_ff.pointer[7:1] == ADDR_RES_DIR_LOW[7:1]) begin
                        nxt_st.res_dir[cur_ff.pointer[0]] = cur_ff.shift;
                     end
                     nxt_st.pointer = {cur_ff.pointer[7:1], ~cur_ff.pointer[0]};
                  end
                  default: begin
                     nxt_st.pointer = {cur_ff.pointer[7:1], ~cur_ff.pointer[0]};
                     nxt_st.phase   = cur_ff.ctl_nack ? ST_SKIP : ST_RDATA;
                  end
               endcase
               if (cur_ff.phase == ST_ADDR && cur_ff.reading || cur_ff.phase == ST_RDATA && !cur_ff.ctl_nack) begin
                  // transmit register that pointer selects
                  // A following read byte comes from the partner that the pointer now selects.
                  nxt_st.shift    = read_reg(cur_ff, cur_ff.phase == ST_RDATA ?
                                             {cur_ff.pointer[7:1], ~cur_ff.pointer[0]} : cur_ff.pointer);
                  nxt_st.tx_drive = 1'b1;
               end
            end else if (cur_ff.bit_cnt == 4'h8) begin
               nxt_st.acking   = 1'b1;
               nxt_st.tx_drive = 1'b0;
               nxt_st.ctl_nack = 1'b0;
               if (cur_ff.phase == ST_ADDR) begin
                  nxt_st.reading = cur_ff.shift[0];
                  if (cur_ff.shift[7:1] == DEV_ADDR) begin
                     nxt_st.ack_drive = 1'b1;
                  end else begin
                     nxt_st.phase  = ST_SKIP;
                     nxt_st.acking = 1'b0;
                  end
               end else if (cur_ff.phase != ST_RDATA) begin
                  nxt_st.ack_drive = 1'b1;
               end
            end else if (cur_ff.tx_drive) begin
               nxt_st.shift = {cur_ff.shift[6:0], 1'b1};
            end
         end
      end
      nxt_st.sda_out  = 1'b0;
      nxt_st.sda_oe_n = ~(nxt_st.ack_drive | (nxt_st.tx_drive & ~nxt_st.shift[7]));
      // Four pins share one drive byte, two code bits each.
      for (int i = 0; i < 16; i++) begin
         nxt_st.half[i] = nxt_st.drive[i / 4][(i % 4) * 2 +: 2] == DRIVE_HALF;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // reset holds defaults
   always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cur_ff          <= '0;
         cur_ff.scl_sync <= 2'h3;
         cur_ff.sda_sync <= 2'h3;
         cur_ff.scl_prev <= 1'b1;
         cur_ff.sda_prev <= 1'b1;
         cur_ff.phase    <= ST_IDLE;
         cur_ff.sda_oe_n <= 1'b1;
         cur_ff.out_lvl  <= {RST_OUTPUT, RST_OUTPUT};
         cur_ff.drive    <= {RST_DRIVE, RST_DRIVE, RST_DRIVE, RST_DRIVE};
         cur_ff.res_con  <= {RST_RES_CONNECT, RST_RES_CONNECT};
         cur_ff.res_dir  <= {RST_RES_DIR, RST_RES_DIR};
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign link.sda_dev_out  = cur_ff.sda_out;
   assign link.sda_dev_oe_n = cur_ff.sda_oe_n;
   assign OUTPUT_LEVEL_OUT  = cur_ff.out_lvl;
   assign RES_CONNECT_OUT   = cur_ff.res_con;
   assign RES_PULL_UP_OUT   = cur_ff.res_dir;
   assign DRIVE_CODE_OUT    = {cur_ff.drive[3], cur_ff.drive[2], cur_ff.drive[1], cur_ff.drive[0]};
   assign HALF_DRIVE_OUT    = cur_ff.half;

endmodule

/* File: verification/expander_link_assertions.sv */
// Protocol checks on the two-wire link, sampled by the controller clock.
module expander_link_assertions (
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic scl_out_in,
   input wire logic scl_oe_n_in,
   input wire logic sda_ctl_out_in,
   input wire logic sda_ctl_oe_n_in,
   input wire logic sda_dev_out_in,
   input wire logic sda_dev_oe_n_in,
   input wire logic scl_in,
   input wire logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   sequence s_start;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   chk_pins_pull_low: assert property (!scl_out_in && !sda_ctl_out_in && !sda_dev_out_in)
      else $error("open-drain driver drives high");
   chk_start_by_ctl: assert property (s_start |-> !sda_ctl_oe_n_in)
      else $error("start not made by the controller");
   chk_stop_by_ctl: assert property (s_stop |-> sda_ctl_oe_n_in && sda_dev_oe_n_in)
      else $error("stop not made by the controller");
   chk_dev_release_start: assert property (s_start |-> sda_dev_oe_n_in)
      else $error("device holds data line at start");
   chk_bus_free: assert property (s_stop |-> sda_in [*4])
      else $error("bus not idle after stop");
   chk_dev_moves_low: assert property ($changed(sda_dev_oe_n_in) |-> !scl_in)
      else $error("device changed data while clock high");
   chk_scl_high_min: assert property ($rose(scl_in) |-> scl_in [*4])
      else $error("clock high phase too short");
   chk_scl_low_min: assert property ($fell(scl_in) |-> !scl_in [*4])
      else $error("clock low phase too short");
   chk_ack_hold: assert property ($fell(sda_dev_oe_n_in) |-> !sda_dev_oe_n_in [*4])
      else $error("device bit released too early");
endmodule

/* File: verification/tb_top.sv */
// Bench joining controller and expander; APB in, register outputs checked.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import expander_pkg::*;
   logic        clk = 0;
   logic        lclk = 0;
   logic        rst_n = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, err;
   logic [31:0] prdata, rd, drv;
   logic [15:0] out_lvl, res_con, res_up, half;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cycles = 0;
   expander_link_if link();
   expander_controller u_expander_controller (.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata), .link(link));
   expander_device u_expander_device (.LINK_CLK_IN(lclk), .RST_N_IN(rst_n), .link(link),
      .OUTPUT_LEVEL_OUT(out_lvl), .RES_CONNECT_OUT(res_con), .RES_PULL_UP_OUT(res_up),
      .DRIVE_CODE_OUT(drv), .HALF_DRIVE_OUT(half));
   expander_link_assertions u_expander_link_assertions (.CLOCK_IN(clk), .RST_N_IN(rst_n),
      .scl_out_in(link.scl_out), .scl_oe_n_in(link.scl_oe_n), .sda_ctl_out_in(link.sda_ctl_out),
      .sda_ctl_oe_n_in(link.sda_ctl_oe_n), .sda_dev_out_in(link.sda_dev_out),
      .sda_dev_oe_n_in(link.sda_dev_oe_n), .scl_in(link.scl), .sda_in(link.sda));
   always #50 clk = ~clk;
   always #24 lclk = ~lclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // The request stands until the rising edge that samples pready high; the answer is taken there.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic xfer(input logic rdn, input logic [7:0] cmd, input logic [7:0] wd, input logic [7:0] n);
      apb(1'b1, APB_CMD, {24'h0, cmd});
      apb(1'b1, APB_WDATA, {24'h0, wd});
      apb(1'b1, APB_CTRL, {16'h0, n, 6'h0, rdn, 1'b1});
      rd = 32'h1;
      while (rd[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, APB_STATUS, 32'h0);
      chk({31'h0, rd[STAT_NACK_BIT]}, 32'h0);
      if (rdn) apb(1'b0, APB_RDATA, 32'h0);
   endtask
   task automatic t_reset;
      chk({16'h0, out_lvl}, {16'h0, {2{RST_OUTPUT}}});
      chk({16'h0, res_con}, {16'h0, {2{RST_RES_CONNECT}}});
      chk({16'h0, res_up}, {16'h0, {2{RST_RES_DIR}}});
      chk(drv, {4{RST_DRIVE}});
      $display("reset values test done");
   endtask
   task automatic t_write;
      xfer(1'b0, ADDR_RES_CONNECT_HI, 8'h3C, 8'h01);
      chk({16'h0, res_con}, 32'h0000_3C00);
      xfer(1'b0, ADDR_RES_DIR_LOW, 8'h0F, 8'h02);
      chk({16'h0, res_up}, 32'h0000_0F0F);
      xfer(1'b0, ADDR_OUTPUT_HIGH, 8'h5A, 8'h03);
      chk({16'h0, out_lvl}, 32'h0000_5A5A);
      xfer(1'b0, ADDR_DRIVE_FIRST, 8'hA6, 8'h01);
      chk(drv, 32'hFFFF_FFA6);
      chk({16'h0, half}, 32'h0000_000D);
      $display("pair write test done");
   endtask
   task automatic t_read;
      xfer(1'b0, ADDR_OUTPUT_LOW, 8'h34, 8'h01);
      chk({16'h0, out_lvl}, 32'h0000_5A34);
      xfer(1'b1, ADDR_OUTPUT_HIGH, 8'h00, 8'h01);
      chk({24'h0, rd[7:0]}, 32'h0000_005A);
      xfer(1'b1, ADDR_OUTPUT_HIGH, 8'h00, 8'h02);
      chk({24'h0, rd[7:0]}, 32'h0000_0034);
      xfer(1'b1, ADDR_OUTPUT_LOW, 8'h00, 8'h04);
      chk({24'h0, rd[7:0]}, 32'h0000_005A);
      $display("pair read test done");
   endtask
   task automatic t_bad;
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("unmapped access test done");
   endtask
   task automatic t_hold;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk({16'h0, out_lvl}, {16'h0, {2{RST_OUTPUT}}});
      chk(drv, {4{RST_DRIVE}});
      rst_n <= 1'b1;
      $display("reset hold test done");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // A hung handshake is cut off well beyond the few thousand cycles the run needs.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_bad();
      t_hold();
      close_out();
   end
endmodule
